// ---- hw/gp_timer_pkg.sv ----
// Constants shared by the general-purpose timer time-base unit.
package gp_timer_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SLAVE   = 8'h04;
    localparam logic [7:0] OFS_CHMODE  = 8'h08;
    localparam logic [7:0] OFS_CHEN    = 8'h0C;
    localparam logic [7:0] OFS_FLAGS   = 8'h10;
    localparam logic [7:0] OFS_EVGEN   = 8'h14;
    localparam logic [7:0] OFS_COUNT   = 8'h18;
    localparam logic [7:0] OFS_PSC     = 8'h1C;
    localparam logic [7:0] OFS_RELOAD  = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN_BIT    = 0;
    localparam int CTL_UDIS_BIT   = 1;
    localparam int CTL_URS_BIT    = 2;
    localparam int CTL_DIR_BIT    = 4;
    localparam int CTL_CENTER_BIT = 5;
    localparam int CTL_ARBE_BIT   = 7;
    localparam int SLV_SMS_LSB    = 0;
    localparam int SLV_TS_LSB     = 4;
    localparam int CHM_SEL_LSB    = 0;
    localparam int CHM_FILT_LSB   = 4;
    localparam int CHE_POL_BIT    = 0;
    localparam int FLG_UPD_BIT    = 0;
    localparam int FLG_TRG_BIT    = 1;
    localparam int EVG_UG_BIT     = 0;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_RELOAD   = 16'hFFFF;
    localparam logic [3:0]  RST_PSC_EXP  = 4'h0;
    localparam logic [15:0] RST_COUNT    = 16'h0000;
    localparam logic [2:0]  SMS_INTERNAL = 3'h0;
    localparam logic [2:0]  SMS_EXT_ONE  = 3'h7;
    localparam logic [2:0]  TS_CHANNEL2  = 3'h6;
    localparam logic [1:0]  CH2_SEL_IN   = 2'h1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// ---- hw/gp_timer_time_base.sv ----
// Time-base unit of a general-purpose timer with an AXI4-Lite register port.
//
// Notes on behaviour
// - 16-bit counter: up, down or centre-aligned.
// - Count, reload, prescale registers always accessible.
// - Reload buffered; copied always or at update.
// - Wrap makes update only while update_disable clear.
// - Counts only while enabled; enable lags one cycle.
// - Debug halt never freezes the timer.
// - Prescale divides by two to the exponent.
// - New prescale ratio applies from next update.
// - Up mode: 0 to reload, wrap, overflow.
// - Update from overflow, underflow or software update_generate.
// - Software update in up mode clears both counters.
// - Software update in down mode reloads counter.
// - Update source select hides software update flag.
// - Update sets flag and loads both shadows.
// - Down mode: reload to 0, restart, underflow.
// - Reload shadow refreshed before counter reload.
// - Centre mode: up to reload, down to 0.
// - Centre mode: hardware owns count_direction.
// - Centre mode: updates at both ends; software restarts.
// - Centre mode keeps counting while updates disabled.
// - Mode 000 counts internal clock; self-clearing update.
// - Mode 111 counts filtered channel2_input edges.
// - Each selected edge counts once, sets trigger flag.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module gp_timer_time_base (
    input  wire logic        core_clk_in,       // 10 MHz clock
    input  wire logic        arst_n_in,         // async reset, low
    input  wire logic [7:0]  s_axi_awaddr_in,   // write address
    input  wire logic        s_axi_awvalid_in,  // write address valid
    output logic             s_axi_awready_out, // write address ready
    input  wire logic [31:0] s_axi_wdata_in,    // write data
    input  wire logic [3:0]  s_axi_wstrb_in,    // write byte strobes
    input  wire logic        s_axi_wvalid_in,   // write data valid
    output logic             s_axi_wready_out,  // write data ready
    output logic [1:0]       s_axi_bresp_out,   // write response
    output logic             s_axi_bvalid_out,  // write response valid
    input  wire logic        s_axi_bready_in,   // write response ready
    input  wire logic [7:0]  s_axi_araddr_in,   // read address
    input  wire logic        s_axi_arvalid_in,  // read address valid
    output logic             s_axi_arready_out, // read address ready
    output logic [31:0]      s_axi_rdata_out,   // read data
    output logic [1:0]       s_axi_rresp_out,   // read response
    output logic             s_axi_rvalid_out,  // read data valid
    input  wire logic        s_axi_rready_in,   // read data ready
    input  wire logic        channel2_input_in, // external pulse pin
    output logic [15:0]      count_out,         // current count
    output logic             count_direction_out, // 1 = counting down
    output logic             update_event_out   // update pulse
);
    import gp_timer_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        counter_run_enable;
        logic        update_disable;
        logic        update_request_source;
        logic        count_direction;
        logic        center_mode;
        logic        autoreload_buffer_enable;
        logic [2:0]  slave_mode_select;
        logic [2:0]  trigger_select;
        logic [1:0]  ch2_select;
        logic [3:0]  ch2_input_filter;
        logic        ch2_polarity;
        logic        update_irq_flag;
        logic        trigger_irq_flag;
        logic        counter_enable_delayed;
        logic [15:0] cnt;
        logic [15:0] psc_cnt;
        logic [3:0]  psc_buf;
        logic [3:0]  psc_sh;
        logic [15:0] arr_buf;
        logic [15:0] arr_sh;
        logic [2:0]  sync;
        logic        flt_lvl;
        logic        flt_prev;
        logic [3:0]  flt_cnt;
        logic        ue;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic        wr_fire;
    logic        update_generate;
    logic        update_event;
    logic        counter_tick;
    logic        ext_edge;
    logic        ovf;
    logic        unf;
    logic [15:0] arr_act;
    logic [15:0] arr_new;
    logic [15:0] psc_max;
    logic [31:0] wmerge;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= OFS_RELOAD);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] a,
                                             input state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            OFS_CONTROL: begin
                r[CTL_RUN_BIT]    = s.counter_run_enable;
                r[CTL_UDIS_BIT]   = s.update_disable;
                r[CTL_URS_BIT]    = s.update_request_source;
                r[CTL_DIR_BIT]    = s.count_direction;
                r[CTL_CENTER_BIT] = s.center_mode;
                r[CTL_ARBE_BIT]   = s.autoreload_buffer_enable;
            end
            OFS_SLAVE: begin
                r[SLV_SMS_LSB +: 3] = s.slave_mode_select;
                r[SLV_TS_LSB +: 3]  = s.trigger_select;
            end
            OFS_CHMODE: begin
                r[CHM_SEL_LSB +: 2]  = s.ch2_select;
                r[CHM_FILT_LSB +: 4] = s.ch2_input_filter;
            end
            OFS_CHEN:   r[CHE_POL_BIT] = s.ch2_polarity;
            OFS_FLAGS: begin
                r[FLG_UPD_BIT] = s.update_irq_flag;
                r[FLG_TRG_BIT] = s.trigger_irq_flag;
            end
            OFS_COUNT:  r[15:0] = s.cnt;
            OFS_PSC:    r[3:0]  = s.psc_buf;
            OFS_RELOAD: r[15:0] = s.arr_buf;
            default:    r = 32'h0000_0000;
        endcase
        reg_read = r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // No debug-halt input exists: the timer has no way to be frozen.
    always_comb begin
        st_nxt  = st_r;
        wmerge  = 32'h0000_0000;
        ovf     = 1'b0;
        unf     = 1'b0;

        // Channel-2 pin: three flops, accepted when stages 2 and 3 agree.
        st_nxt.sync = {st_r.sync[1:0], channel2_input_in};
        if (st_r.sync[1] == st_r.sync[2] && st_r.sync[2] != st_r.flt_lvl)
        begin
            if (st_r.flt_cnt >= st_r.ch2_input_filter) begin
                st_nxt.flt_lvl = st_r.sync[2];
                st_nxt.flt_cnt = 4'h0;
            end else begin
                st_nxt.flt_cnt = st_r.flt_cnt + 4'h1;
            end
        end else begin
            st_nxt.flt_cnt = 4'h0;
        end
        st_nxt.flt_prev = st_r.flt_lvl;
        ext_edge = (st_r.slave_mode_select == SMS_EXT_ONE)
                && (st_r.trigger_select == TS_CHANNEL2)
                && (st_r.ch2_select == CH2_SEL_IN)
                && (st_r.ch2_polarity ? (st_r.flt_prev & ~st_r.flt_lvl)
                                      : (st_r.flt_lvl & ~st_r.flt_prev));

        // Prescaler driven by the selected source.
        st_nxt.counter_enable_delayed = st_r.counter_run_enable;
        psc_max = 16'((32'h1 << st_r.psc_sh) - 32'h1);
        counter_tick = 1'b0;
        if (st_r.counter_enable_delayed &&
            ((st_r.slave_mode_select == SMS_INTERNAL) || ext_edge)) begin
            if (st_r.psc_cnt >= psc_max) begin
                st_nxt.psc_cnt = 16'h0000;
                counter_tick   = 1'b1;
            end else begin
                st_nxt.psc_cnt = st_r.psc_cnt + 16'h0001;
            end
        end

        // Bus write decode; update_generate exists only in this cycle.
        wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        update_generate = wr_fire && (st_r.aw_addr == OFS_EVGEN)
                       && st_r.w_strb[0] && st_r.w_data[EVG_UG_BIT];

        // Wrap detection.
        arr_act = st_r.autoreload_buffer_enable ? st_r.arr_sh
                                                : st_r.arr_buf;
        if (counter_tick && !update_generate) begin
            if (st_r.center_mode) begin
                ovf = !st_r.count_direction &&
                      ({1'b0, st_r.cnt} + 17'h1 >= {1'b0, arr_act});
                unf = st_r.count_direction && (st_r.cnt <= 16'h0001);
            end else if (st_r.count_direction) begin
                unf = (st_r.cnt == 16'h0000);
            end else begin
                ovf = (st_r.cnt >= arr_act);
            end
        end
        update_event = !st_r.update_disable &&
                       (update_generate || ovf || unf);
        // The new reload reaches the counter in the same edge.
        arr_new = update_event ? st_r.arr_buf : arr_act;

        // Counter.
        if (update_generate) begin
            st_nxt.psc_cnt = 16'h0000;
            if (!st_r.center_mode && st_r.count_direction) begin
                st_nxt.cnt = arr_new;
            end else begin
                st_nxt.cnt = 16'h0000;
                if (st_r.center_mode) begin
                    st_nxt.count_direction = 1'b0;
                end
            end
        end else if (counter_tick) begin
            if (st_r.center_mode) begin
                if (ovf) begin
                    st_nxt.cnt = arr_act;
                    st_nxt.count_direction = 1'b1;
                end else if (unf) begin
                    st_nxt.cnt = 16'h0000;
                    st_nxt.count_direction = 1'b0;
                end else if (st_r.count_direction) begin
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end else begin
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end
            end else if (st_r.count_direction) begin
                st_nxt.cnt = unf ? arr_new
                                 : st_r.cnt - 16'h0001;
            end else begin
                st_nxt.cnt = ovf ? 16'h0000
                                 : st_r.cnt + 16'h0001;
            end
        end

        // Shadows.
        if (update_event) begin
            st_nxt.arr_sh = st_r.arr_buf;
            st_nxt.psc_sh = st_r.psc_buf;
        end else if (!st_r.autoreload_buffer_enable) begin
            st_nxt.arr_sh = st_r.arr_buf;
        end

        // Flags: a hardware set wins over a same-cycle clear.
        if (wr_fire && st_r.aw_addr == OFS_FLAGS && st_r.w_strb[0]) begin
            if (st_r.w_data[FLG_UPD_BIT]) begin
                st_nxt.update_irq_flag = 1'b0;
            end
            if (st_r.w_data[FLG_TRG_BIT]) begin
                st_nxt.trigger_irq_flag = 1'b0;
            end
        end
        // update_request_source keeps update_generate from setting the flag.
        if (update_event &&
            !(update_generate && st_r.update_request_source)) begin
            st_nxt.update_irq_flag = 1'b1;
        end
        if (ext_edge) begin
            st_nxt.trigger_irq_flag = 1'b1;
        end
        st_nxt.ue = update_event;

        // Register writes; software may touch any of these at any time.
        if (wr_fire) begin
            wmerge = merge(reg_read(st_r.aw_addr, st_r), st_r.w_data,
                           st_r.w_strb);
            unique case (st_r.aw_addr)
                OFS_CONTROL: begin
                    st_nxt.counter_run_enable = wmerge[CTL_RUN_BIT];
                    st_nxt.update_disable     = wmerge[CTL_UDIS_BIT];
                    st_nxt.update_request_source = wmerge[CTL_URS_BIT];
                    st_nxt.center_mode        = wmerge[CTL_CENTER_BIT];
                    st_nxt.autoreload_buffer_enable = wmerge[CTL_ARBE_BIT];
                    if (!st_r.center_mode) begin
                        st_nxt.count_direction = wmerge[CTL_DIR_BIT];
                    end
                end
                OFS_SLAVE: begin
                    st_nxt.slave_mode_select = wmerge[SLV_SMS_LSB +: 3];
                    st_nxt.trigger_select    = wmerge[SLV_TS_LSB +: 3];
                end
                OFS_CHMODE: begin
                    st_nxt.ch2_select       = wmerge[CHM_SEL_LSB +: 2];
                    st_nxt.ch2_input_filter = wmerge[CHM_FILT_LSB +: 4];
                end
                OFS_CHEN:   st_nxt.ch2_polarity = wmerge[CHE_POL_BIT];
                OFS_COUNT:  st_nxt.cnt     = wmerge[15:0];
                OFS_PSC:    st_nxt.psc_buf = wmerge[3:0];
                OFS_RELOAD: st_nxt.arr_buf = wmerge[15:0];
                default:    st_nxt.psc_buf = st_r.psc_buf;
            endcase
        end

        // AXI4-Lite handshakes.
        if (s_axi_awvalid_in && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata_in;
            st_nxt.w_strb = s_axi_wstrb_in;
        end
        if (wr_fire) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = is_mapped(st_r.aw_addr) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end else if (st_r.bvalid && s_axi_bready_in) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = reg_read(s_axi_araddr_in, st_r);
            st_nxt.rresp  = is_mapped(s_axi_araddr_in) ? RESP_OKAY
                                                       : RESP_SLVERR;
        end else if (st_r.rvalid && s_axi_rready_in) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r         <= '0;
            st_r.cnt     <= RST_COUNT;
            st_r.psc_buf <= RST_PSC_EXP;
            st_r.psc_sh  <= RST_PSC_EXP;
            st_r.arr_buf <= RST_RELOAD;
            st_r.arr_sh  <= RST_RELOAD;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready_out   = !st_r.aw_held;
    assign s_axi_wready_out    = !st_r.w_held;
    assign s_axi_bvalid_out    = st_r.bvalid;
    assign s_axi_bresp_out     = st_r.bresp;
    assign s_axi_arready_out   = !st_r.rvalid;
    assign s_axi_rvalid_out    = st_r.rvalid;
    assign s_axi_rdata_out     = st_r.rdata;
    assign s_axi_rresp_out     = st_r.rresp;
    assign count_out           = st_r.cnt;
    assign count_direction_out = st_r.count_direction;
    assign update_event_out    = st_r.ue;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_enable_lag;
        $rose(st_r.counter_run_enable) |=> st_r.counter_enable_delayed;
    endproperty
    a_enable_lag: assert property (p_enable_lag)
        else $error("delayed enable did not follow run enable");

    property p_no_update_when_disabled;
        st_r.update_disable |=> !update_event_out;
    endproperty
    a_no_update_when_disabled:
        assert property (p_no_update_when_disabled)
        else $error("update event while updates disabled");

    property p_up_wrap;
        (ovf && !st_r.center_mode) |=> (st_r.cnt == 16'h0000)
            && update_event_out == !$past(st_r.update_disable);
    endproperty
    a_up_wrap: assert property (p_up_wrap)
        else $error("up-count overflow did not wrap to zero");

    property p_down_wrap;
        unf && !st_r.center_mode |=> st_r.cnt == $past(arr_new);
    endproperty
    a_down_wrap: assert property (p_down_wrap)
        else $error("down-count underflow did not reload");

    property p_flag_set;
        update_event && !(update_generate && st_r.update_request_source)
            |=> st_r.update_irq_flag ##1 1'b1;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("update flag not set by update event");

    property p_urs_hides;
        update_generate && st_r.update_request_source
            && !st_r.update_irq_flag |=> !st_r.update_irq_flag;
    endproperty
    a_urs_hides: assert property (p_urs_hides)
        else $error("software update set flag despite source select");

    property p_psc_shadow;
        update_event |=> st_r.psc_sh == $past(st_r.psc_buf)
            && st_r.arr_sh == $past(st_r.arr_buf);
    endproperty
    a_psc_shadow: assert property (p_psc_shadow)
        else $error("shadows not loaded on update event");

    property p_ug_restart;
        update_generate && !(st_r.count_direction && !st_r.center_mode)
            |=> st_r.cnt == 16'h0000 && st_r.psc_cnt == 16'h0000;
    endproperty
    a_ug_restart: assert property (p_ug_restart)
        else $error("software update did not restart counters");

    property p_trigger_flag;
        ext_edge |=> st_r.trigger_irq_flag;
    endproperty
    a_trigger_flag: assert property (p_trigger_flag)
        else $error("selected edge did not set trigger flag");

endmodule

`default_nettype wire

// ---- verification/ch2_pulse_source.sv ----
// Model of the pulse source wired to the timer's channel-two pin.
`timescale 1ns/1ns
`default_nettype none

module ch2_pulse_source (
    input  wire logic clk_in,   // timer clock
    input  wire logic fire_in,  // start one pulse
    output logic      pin_out,  // level on the channel pin
    output logic      busy_out  // pulse still running
);
    logic [4:0] left_r = 5'h00;

    // High for 16 cycles, low for 15: each level outlasts the pin's
    // resynchroniser, so every rising edge must be counted once.
    always_ff @(posedge clk_in) begin
        if (fire_in && left_r == 5'h00) begin
            left_r <= 5'h1F;
        end else if (left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
        end
    end
    assign pin_out  = left_r > 5'h0F;
    assign busy_out = left_r != 5'h00;
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the timer time-base unit.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import gp_timer_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, fire = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, q;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [1:0] r;
    wire logic awready, wready, bvalid, arready, rvalid, dir, upd, pin, busy;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] cnt;
    int fail_count = 0, n_compared = 0, n;

    gp_timer_time_base u_gp_timer_time_base (.core_clk_in(clk),
        .arst_n_in(arst_n), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .channel2_input_in(pin), .count_out(cnt),
        .count_direction_out(dir), .update_event_out(upd));
    ch2_pulse_source u_ch2_pulse_source (.clk_in(clk), .fire_in(fire),
        .pin_out(pin), .busy_out(busy));

    // ------------------------------------------------------------------
    // Bus tasks: ready is looked at mid-cycle, where it already holds
    // the value that the next rising edge samples.
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk); aw = awready; w = wready; b = bvalid;
            if (b) chk("bresp", RESP_OKAY, bresp);
            @(posedge clk);
            if (aw) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end while (!b);
        bready <= 1'h0;
        // One edge passes so that a following call never raises the
        // response ready again in the time step that lowered it.
        @(posedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        logic ar, v;
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin
            @(negedge clk); ar = arready; v = rvalid; q = rdata; r = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'h0;
        end while (!v);
        rready <= 1'h0;
        @(posedge clk);
        chk(nm, e, q);
    endtask

    // Cycles between two update pulses, counted from the second pulse seen to the third.
    task automatic per(input int e, input string nm);
        repeat (2) begin
            while (upd !== 1'h1) @(negedge clk);
            @(negedge clk);
        end
        n = 1;
        while (upd !== 1'h1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(nm, e, n);
        @(posedge clk);
    endtask

    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 20000);
        fail_count++;
        report_and_stop;
    end

    task automatic pulse;
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        @(negedge clk);
        while (busy) @(negedge clk);
        @(posedge clk);
    endtask

    task automatic t_reset_values;
        rchk(OFS_RELOAD, 32'h0000FFFF, "reload");
        rchk(OFS_PSC, 32'h0, "psc");
        rchk(OFS_COUNT, 32'h0, "count");
        rchk(8'h3C, 32'h0, "unmapped");
        chk("unmapped resp", RESP_SLVERR, r);
    endtask

    task automatic t_modes;
        wr(OFS_RELOAD, 32'h3);
        wr(OFS_CONTROL, 32'h01);
        per(4, "up period");
        wr(OFS_CONTROL, 32'h03);
        repeat (3) @(negedge clk);
        n = 0;
        repeat (20) begin
            @(negedge clk);
            if (upd !== 1'h0) n++;
        end
        chk("disabled updates", 0, n);
        @(posedge clk);
        wr(OFS_CONTROL, 32'h11);
        per(4, "down period");
        chk("down dir", 1'h1, dir);
        wr(OFS_CONTROL, 32'h21);
        per(3, "centre period");
        wr(OFS_CONTROL, 32'h01);
        wr(OFS_PSC, 32'h2);
        per(16, "prescaled period");
    endtask

    task automatic t_soft_update;
        wr(OFS_CONTROL, 32'h04);
        wr(OFS_FLAGS, 32'h3);
        wr(OFS_EVGEN, 32'h1);
        rchk(OFS_FLAGS, 32'h0, "hidden flag");
        rchk(OFS_EVGEN, 32'h0, "ug reads 0");
        wr(OFS_CONTROL, 32'h00);
        wr(OFS_PSC, 32'h0);
        wr(OFS_RELOAD, 32'hFFFF);
        wr(OFS_CONTROL, 32'h10);
        wr(OFS_EVGEN, 32'h1);
        rchk(OFS_FLAGS, 32'h1, "update flag");
        rchk(OFS_COUNT, 32'hFFFF, "ug reload");
        wr(OFS_CONTROL, 32'h00);
        wr(OFS_EVGEN, 32'h1);
        rchk(OFS_COUNT, 32'h0, "ug restart");
    endtask

    task automatic t_ext_clock;
        wr(OFS_CHMODE, 32'h1);
        wr(OFS_CHEN, 32'h0);
        wr(OFS_SLAVE, 32'h67);
        wr(OFS_FLAGS, 32'h3);
        wr(OFS_CONTROL, 32'h01);
        repeat (3) pulse;
        chk("edges counted", 16'h3, cnt);
        rchk(OFS_FLAGS, 32'h2, "trigger flag");
        wr(OFS_CHMODE, 32'h21);
        wr(OFS_CHEN, 32'h1);
        pulse;
        chk("falling edge", 16'h4, cnt);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        t_reset_values;
        t_modes;
        t_soft_update;
        t_ext_clock;
        report_and_stop;
    end
endmodule

`default_nettype wire
